// ---- verilog/lcsi_pkg.sv ----
// Behaviour
// (R1) Bit 1 shows live receive signal loss
// (R2) Signal loss change raises enabled interrupt
// (R3) Bit 0 shows live test pattern lock
// (R4) Pattern lock change raises enabled interrupt
// (R5) Registers work only in single rail mode
// (R6) Bit 6 latches drive monitor alarm changes
// (R7) Bit 5 latches FIFO limit changes
// (R8) Bit 4 latches code violation changes
// (R9) Bit 3 latches loop code changes
// (R10) Reading latches clears them; reset zero
// (R11) Code violation latch for framer bypass only; code has no bypass, always latches it
// (R12) Latch bit 7 reserved, reads zero
// (R13) Alarm after 128 quiet bits, clears instantly
// (R14) FIFO limit while pointers within three
// (R15) Interrupt while enabled latch stays set
`default_nettype none
package lcsi_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LATCH  = 8'h08;
  localparam logic [7:0] OFS_MODE   = 8'h0C;
  localparam logic [7:0] OFS_NONE   = 8'hFF;

  // ------------------------------------------------------------
  // Field positions, same layout in enable, status and latches
  // ------------------------------------------------------------
  localparam int B_LOCK = 0;
  localparam int B_LOSS = 1;
  localparam int B_LOOP = 3;
  localparam int B_CV   = 4;
  localparam int B_FIFO = 5;
  localparam int B_DM   = 6;
  localparam int B_MODE = 0;
  localparam logic [7:0] LIVE_MASK = 8'h7B;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic       MODE_RST   = 1'b1;

  // ------------------------------------------------------------
  // Counts and synchroniser lanes
  // ------------------------------------------------------------
  localparam logic [7:0] DM_QUIET_BITS = 8'h80;
  localparam int         JA_PTR_W      = 5;
  localparam logic [4:0] JA_NEAR_LO    = 5'h03;
  localparam logic [4:0] JA_NEAR_HI    = 5'(2 ** JA_PTR_W - 3);
  localparam int SYNC_N  = 7;
  localparam int SY_LOCK = 0;
  localparam int SY_LOSS = 1;
  localparam int SY_CV   = 2;
  localparam int SY_LOOP = 3;
  localparam int SY_BCLK = 4;
  localparam int SY_TXP  = 5;
  localparam int SY_TXN  = 6;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } lcsi_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } lcsi_ahb_out_t;

  typedef struct packed {
    logic                rx_signal_loss_flag;
    logic                test_pattern_lock_flag;
    logic                code_violation_flag;
    logic                loop_code_detect_flag;
    logic                tx_bit_clk;
    logic                tx_pos_pulse;
    logic                tx_neg_pulse;
    logic [JA_PTR_W-1:0] ja_wr_ptr;
    logic [JA_PTR_W-1:0] ja_rd_ptr;
  } lcsi_line_in_t;

  typedef struct packed {
    logic [SYNC_N-1:0] sy1;
    logic [SYNC_N-1:0] sy2;
    logic [SYNC_N-1:0] sy3;
    logic [SYNC_N-1:0] filt;
    logic [7:0]        dm_cnt;
    logic [7:0]        live;
    logic [7:0]        enable;
    logic [7:0]        latch;
    logic              mode;
    logic              dp_valid;
    logic              dp_write;
    logic [7:0]        dp_addr;
    logic              irq;
    lcsi_ahb_out_t     bus;
  } lcsi_state_t;

endpackage : lcsi_pkg
`default_nettype wire

// ---- verilog/lcsi_top.sv ----
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module lcsi_top (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire lcsi_pkg::lcsi_ahb_in_t  ahb_i,
  output wire lcsi_pkg::lcsi_ahb_out_t ahb_o,
  input  wire lcsi_pkg::lcsi_line_in_t line_i,
  output wire logic                    irq
);
  import lcsi_pkg::*;

  lcsi_state_t s_r;
  lcsi_state_t s_nxt;

  logic [SYNC_N-1:0]   pins;
  logic [JA_PTR_W-1:0] ja_gap;
  logic                ja_near;
  logic                bit_edge;
  logic                tx_active;
  logic [7:0]          events;
  logic                acc;
  logic [7:0]          adr;
  logic                wr_en;
  logic [7:0]          w1c;
  logic                lat_rd;
  logic [7:0]          en_now;
  logic                mode_now;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    pins = '0;
    pins[SY_LOCK] = line_i.test_pattern_lock_flag;
    pins[SY_LOSS] = line_i.rx_signal_loss_flag;
    pins[SY_CV]   = line_i.code_violation_flag;
    pins[SY_LOOP] = line_i.loop_code_detect_flag;
    pins[SY_BCLK] = line_i.tx_bit_clk;
    pins[SY_TXP]  = line_i.tx_pos_pulse;
    pins[SY_TXN]  = line_i.tx_neg_pulse;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Three stages; a level counts only once stages two and three agree
    s_nxt.sy1 = pins;
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    for (int i = 0; i < SYNC_N; i++) begin
      if (s_r.sy2[i] == s_r.sy3[i]) begin
        s_nxt.filt[i] = s_r.sy2[i];
      end
    end

    // ------------------------------------------------------------
    // Drive monitor
    // ------------------------------------------------------------
    // Quiet bit counter saturates so the alarm holds steady
    bit_edge  = s_nxt.filt[SY_BCLK] & ~s_r.filt[SY_BCLK];
    tx_active = s_nxt.filt[SY_TXP] | s_nxt.filt[SY_TXN];
    if (tx_active) begin
      s_nxt.dm_cnt = 8'h00; // see (R13)
    end else if (bit_edge && s_r.dm_cnt != DM_QUIET_BITS) begin
      s_nxt.dm_cnt = s_r.dm_cnt + 8'h01; // see (R13)
    end

    // ------------------------------------------------------------
    // FIFO limit
    // ------------------------------------------------------------
    // Pointers share our clock, no synchroniser needed
    ja_gap  = line_i.ja_wr_ptr - line_i.ja_rd_ptr;
    ja_near = (ja_gap <= JA_NEAR_LO) || (ja_gap >= JA_NEAR_HI); // see (R14)

    // ------------------------------------------------------------
    // Live status
    // ------------------------------------------------------------
    s_nxt.live         = '0;
    s_nxt.live[B_LOCK] = s_nxt.filt[SY_LOCK]; // see (R3)
    s_nxt.live[B_LOSS] = s_nxt.filt[SY_LOSS]; // see (R1)
    s_nxt.live[B_LOOP] = s_nxt.filt[SY_LOOP];
    s_nxt.live[B_CV]   = s_nxt.filt[SY_CV];
    s_nxt.live[B_FIFO] = ja_near; // see (R14)
    s_nxt.live[B_DM]   = (s_nxt.dm_cnt == DM_QUIET_BITS); // see (R13)
    events = (s_nxt.live ^ s_r.live) & LIVE_MASK;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Bus: address phase decode, write in the data phase
    acc   = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
    adr   = (ahb_i.haddr[31:8] == 24'h000000) ? ahb_i.haddr[7:0] : OFS_NONE;
    wr_en = s_r.dp_valid & s_r.dp_write;
    w1c   = 8'h00;
    en_now   = s_r.enable;
    mode_now = s_r.mode;
    if (wr_en) begin
      case (s_r.dp_addr)
        OFS_ENABLE: begin
          if (s_r.mode) begin
            s_nxt.enable = ahb_i.hwdata[7:0] & LIVE_MASK; // see (R5)
            en_now       = s_nxt.enable;
          end
        end
        OFS_LATCH: begin
          if (s_r.mode) begin
            w1c = ahb_i.hwdata[7:0] & LIVE_MASK;
          end
        end
        OFS_MODE: begin
          s_nxt.mode = ahb_i.hwdata[B_MODE];
          mode_now   = s_nxt.mode;
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------
    // Change latches
    // ------------------------------------------------------------
    // Set wins over read clear and write-one clear
    lat_rd = acc & ~ahb_i.hwrite & (adr == OFS_LATCH) & mode_now;
    s_nxt.latch = (s_r.latch & ~((lat_rd ? LIVE_MASK : 8'h00) | w1c)) // see (R10)
                | (s_r.mode ? events : 8'h00); // see (R2) see (R4) see (R6) see (R7) see (R8) see (R9)

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    s_nxt.dp_valid = acc;
    s_nxt.dp_write = ahb_i.hwrite;
    s_nxt.dp_addr  = adr;
    s_nxt.bus.hreadyout = 1'b1;
    s_nxt.bus.hresp     = 1'b0;
    s_nxt.bus.hrdata    = 32'h00000000;
    if (acc && !ahb_i.hwrite) begin
      case (adr)
        OFS_ENABLE: s_nxt.bus.hrdata[7:0] = mode_now ? en_now : 8'h00; // see (R5)
        OFS_STATUS: s_nxt.bus.hrdata[7:0] = mode_now ? s_r.live : 8'h00; // see (R1) see (R3)
        OFS_LATCH:  s_nxt.bus.hrdata[7:0] = mode_now ? (s_r.latch & ~w1c) : 8'h00; // see (R12)
        OFS_MODE:   s_nxt.bus.hrdata[B_MODE] = mode_now;
        default:    s_nxt.bus.hrdata = 32'h00000000;
      endcase
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Interrupt follows the latches in the same edge they set
    s_nxt.irq = (|(s_nxt.latch & s_nxt.enable)) & s_nxt.mode; // see (R15) see (R5)
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r               <= '0;
      s_r.enable        <= ENABLE_RST;
      s_r.latch         <= LATCH_RST; // see (R10)
      s_r.mode          <= MODE_RST;
      s_r.dp_addr       <= OFS_NONE;
      s_r.bus.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ahb_o = s_r.bus;
  assign irq   = s_r.irq;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  AST_LOSS_LIVE: assert property ( // see (R1)
    line_i.rx_signal_loss_flag [*5] |-> s_r.live[B_LOSS]
  ) else $error("Signal loss status not shown");

  AST_LOSS_IRQ: assert property ( // see (R2)
    $changed(s_r.live[B_LOSS]) && $past(s_r.mode) && s_r.mode && s_r.enable[B_LOSS]
      |-> s_r.latch[B_LOSS] && s_r.irq
  ) else $error("Signal loss change gave no interrupt");

  AST_LOCK_LIVE: assert property ( // see (R3)
    !line_i.test_pattern_lock_flag [*5] |-> !s_r.live[B_LOCK]
  ) else $error("Pattern lock status stuck high");

  AST_LOCK_IRQ: assert property ( // see (R4)
    $changed(s_r.live[B_LOCK]) && $past(s_r.mode) && s_r.mode && s_r.enable[B_LOCK]
      |-> s_r.irq
  ) else $error("Pattern lock change gave no interrupt");

  AST_MODE_OFF: assert property ( // see (R5)
    !s_r.mode && !$past(s_r.mode) |-> !s_r.irq && (s_r.latch == $past(s_r.latch))
  ) else $error("Registers active outside single rail mode");

  AST_DM_LATCH: assert property ( // see (R6)
    $changed(s_r.live[B_DM]) && $past(s_r.mode) |-> s_r.latch[B_DM]
  ) else $error("Drive monitor change not latched");

  AST_FIFO_LATCH: assert property ( // see (R7)
    $changed(s_r.live[B_FIFO]) && $past(s_r.mode) |-> s_r.latch[B_FIFO]
  ) else $error("FIFO limit change not latched");

  AST_CV_LATCH: assert property ( // see (R8)
    $changed(s_r.live[B_CV]) && $past(s_r.mode) |-> s_r.latch[B_CV]
  ) else $error("Code violation change not latched");

  AST_LOOP_LATCH: assert property ( // see (R9)
    $changed(s_r.live[B_LOOP]) && $past(s_r.mode) |-> s_r.latch[B_LOOP]
  ) else $error("Loop code change not latched");

  AST_READ_CLEARS: assert property ( // see (R10)
    lat_rd |=> (s_r.latch & ~(s_r.live ^ $past(s_r.live))) == 8'h00
  ) else $error("Latch read did not clear");

  AST_RSVD_ZERO: assert property ( // see (R12)
    s_r.bus.hrdata[31:7] == 25'h0000000 && !s_r.bus.hrdata[2]
  ) else $error("Reserved read data bits set");

  AST_DM_ACTIVE: assert property ( // see (R13)
    line_i.tx_pos_pulse [*2] |-> ##3 (!s_r.live[B_DM] && s_r.dm_cnt == 8'h00)
  ) else $error("Drive monitor alarm with line activity");

  AST_DM_COUNT: assert property ( // see (R13)
    $rose(s_r.live[B_DM]) |-> $past(s_r.dm_cnt) == 8'h7F
  ) else $error("Drive monitor alarm at wrong count");

  AST_FIFO_NEAR: assert property ( // see (R14)
    ($past(line_i.ja_wr_ptr - line_i.ja_rd_ptr) == 5'h03) |-> s_r.live[B_FIFO]
  ) else $error("FIFO limit missed a close pointer pair");

  AST_IRQ_IDLE: assert property ( // see (R15)
    (s_r.latch & s_r.enable) == 8'h00 |-> !s_r.irq
  ) else $error("Interrupt without enabled latch");

  // ------------------------------------------------------------
  // Bus read checks
  // ------------------------------------------------------------

  AST_LOSS_READ: assert property ( // see (R1)
    acc && !ahb_i.hwrite && adr == OFS_STATUS && mode_now
      |=> s_r.bus.hrdata[B_LOSS] == $past(s_r.live[B_LOSS])
  ) else $error("Signal loss read wrong");

  AST_LOCK_READ: assert property ( // see (R3)
    acc && !ahb_i.hwrite && adr == OFS_STATUS && mode_now
      |=> s_r.bus.hrdata[B_LOCK] == $past(s_r.live[B_LOCK])
  ) else $error("Pattern lock read wrong");

  AST_MODE_READ_ZERO: assert property ( // see (R5)
    acc && !ahb_i.hwrite && !mode_now
      |=> s_r.bus.hrdata == 32'h00000000
  ) else $error("Read data outside single rail mode");

  AST_READ_DATA: assert property ( // see (R10)
    lat_rd && !wr_en
      |=> s_r.bus.hrdata[7:0] == $past(s_r.latch)
  ) else $error("Latch read lost its value");

  // ------------------------------------------------------------
  // Latch and enable checks
  // ------------------------------------------------------------

  AST_MODE_EN_HOLD: assert property ( // see (R5)
    !s_r.mode |=> s_r.enable == $past(s_r.enable)
  ) else $error("Enable written outside single rail mode");

  AST_SET_ONLY: assert property ( // see (R10)
    (s_r.latch & ~$past(s_r.latch) & ~(s_r.live ^ $past(s_r.live))) == 8'h00
  ) else $error("Latch set without a change");

  AST_LATCH_W1C: assert property ( // see (R10)
    wr_en && s_r.dp_addr == OFS_LATCH && s_r.mode
      |=> (s_r.latch & $past(ahb_i.hwdata[7:0]) & LIVE_MASK & ~(s_r.live ^ $past(s_r.live))) == 8'h00
  ) else $error("Write one did not clear latch");

  AST_LATCH_RSVD: assert property ( // see (R12)
    (s_r.latch & ~LIVE_MASK) == 8'h00
  ) else $error("Reserved latch bit set");

  AST_ENABLE_RSVD: assert property ( // see (R2)
    (s_r.enable & ~LIVE_MASK) == 8'h00
  ) else $error("Reserved enable bit set");

  // ------------------------------------------------------------
  // Monitor and interrupt checks
  // ------------------------------------------------------------

  AST_LOSS_FILTER: assert property ( // see (R1)
    $changed(s_r.live[B_LOSS])
      |-> s_r.live[B_LOSS] == $past(s_r.sy3[SY_LOSS]) && s_r.live[B_LOSS] == $past(s_r.sy2[SY_LOSS])
  ) else $error("Signal loss passed the filter early");

  AST_LOCK_FILTER: assert property ( // see (R3)
    $changed(s_r.live[B_LOCK])
      |-> s_r.live[B_LOCK] == $past(s_r.sy3[SY_LOCK]) && s_r.live[B_LOCK] == $past(s_r.sy2[SY_LOCK])
  ) else $error("Pattern lock passed the filter early");

  AST_DM_SAT: assert property ( // see (R13)
    s_r.dm_cnt <= DM_QUIET_BITS
  ) else $error("Quiet bit counter overran");

  AST_DM_CLEAR: assert property ( // see (R13)
    s_r.filt[SY_TXP] || s_r.filt[SY_TXN]
      |-> !s_r.live[B_DM] && s_r.dm_cnt == 8'h00
  ) else $error("Drive monitor alarm held through a pulse");

  AST_FIFO_FAR: assert property ( // see (R14)
    ($past(line_i.ja_wr_ptr - line_i.ja_rd_ptr) == 5'h04) |-> !s_r.live[B_FIFO]
  ) else $error("FIFO limit set for a distant pair");

  AST_FIFO_WRAP: assert property ( // see (R14)
    ($past(line_i.ja_wr_ptr - line_i.ja_rd_ptr) == 5'h1D) |-> s_r.live[B_FIFO]
  ) else $error("FIFO limit missed a wrapped pair");

  AST_IRQ_SET: assert property ( // see (R15)
    (s_r.latch & s_r.enable) != 8'h00 && s_r.mode
      |-> s_r.irq
  ) else $error("Enabled latch gave no interrupt");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  COV_LOSS_IRQ: cover property ($rose(s_r.irq) && s_r.latch[B_LOSS]);
  COV_DM_ALARM: cover property ($rose(s_r.live[B_DM]));
  COV_READ_CLR: cover property (lat_rd && s_r.latch != 8'h00 ##1 s_r.latch == 8'h00);
  COV_SET_WINS: cover property (lat_rd && events != 8'h00);
  COV_W1C:      cover property (wr_en && s_r.dp_addr == OFS_LATCH && s_r.latch != 8'h00);

endmodule : lcsi_top
`default_nettype wire

// ---- verilog/lcsi_top_unused_marker.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- dv/lcsi_line_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lcsi_line_model (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic [7:0]              pins,
  input  wire logic                    tx_on,
  input  wire logic [4:0]              wp,
  input  wire logic [4:0]              rp,
  output wire lcsi_pkg::lcsi_line_in_t line_o
);
  import lcsi_pkg::*;
  // ------------------------------------------------------------
  // Free running bit clock, four system cycles per bit
  // ------------------------------------------------------------
  logic [2:0] ph_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end

  // Pulses last two cycles so the input filter keeps them
  assign line_o = '{rx_signal_loss_flag: pins[B_LOSS], test_pattern_lock_flag: pins[B_LOCK],
                    code_violation_flag: pins[B_CV], loop_code_detect_flag: pins[B_LOOP],
                    tx_bit_clk: ph_r[1],
                    tx_pos_pulse: tx_on & ~ph_r[1] & ph_r[2],
                    tx_neg_pulse: tx_on & ~ph_r[1] & ~ph_r[2],
                    ja_wr_ptr: wp, ja_rd_ptr: rp};
endmodule : lcsi_line_model
`default_nettype wire

// ---- dv/test_liu_channel_status_irq.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_liu_channel_status_irq;
  import lcsi_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic          sys_clk;
  logic          arst_n;
  logic          sel;
  logic [1:0]    trn;
  logic [7:0]    adr;
  logic          wrt;
  logic [7:0]    wdat;
  logic [7:0]    pins;
  logic          tx_on;
  logic [4:0]    wp;
  logic [4:0]    rp;
  logic          irq;
  int            err_count;
  int            checked;
  lcsi_ahb_in_t  ahb_i;
  lcsi_ahb_out_t ahb_o;
  lcsi_line_in_t line_i;

  always #25 sys_clk = ~sys_clk;
  assign ahb_i = '{hsel: sel, haddr: {24'h000000, adr}, htrans: trn, hwrite: wrt, hsize: 3'h2,
                   hready: ahb_o.hreadyout, hwdata: {24'h000000, wdat}};

  lcsi_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .ahb_i(ahb_i), .ahb_o(ahb_o), .line_i(line_i), .irq(irq));
  lcsi_line_model line_u (.sys_clk(sys_clk), .arst_n(arst_n), .pins(pins), .tx_on(tx_on), .wp(wp), .rp(rp),
                          .line_o(line_i));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Sampled at the falling edge, where registered outputs have settled
  task automatic wait_rdy(output logic [7:0] rd);
    int   n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    while (!rdy) begin
      @(negedge sys_clk);
      rdy = (ahb_o.hreadyout === 1'b1);
      rd = ahb_o.hrdata[7:0];
      @(posedge sys_clk);
      n++;
      if (n > 50) begin
        err_count++;
        print_verdict();
      end
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    sel <= 1'b1;
    trn <= 2'h2;
    adr <= a;
    wrt <= wr;
    wait_rdy(rd);
    sel <= 1'b0;
    trn <= 2'h0;
    wdat <= wd;
    wait_rdy(rd);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] rd;
    bus(1'b0, a, 8'h00, rd);
    chk(rd & mask, exp);
  endtask : rd_chk

  function automatic logic fifo_near(input logic [4:0] w, input logic [4:0] r);
    logic [4:0] d;
    d = w - r;
    return (d <= 5'h03) || (d >= 5'h1D);
  endfunction : fifo_near

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    int         bits [4];
    logic [4:0] dlt [7];
    logic [7:0] rd;
    logic       en;
    logic       near_p;
    int         b;
    bits = '{0, 1, 3, 4};
    dlt = '{5'h04, 5'h03, 5'h1C, 5'h1D, 5'h00, 5'h1F, 5'h10};
    sys_clk = 1'b0;
    arst_n = 1'b0;
    tx_on = 1'b1;
    {sel, trn, adr, wrt, wdat, pins, wp, rp} = '0;
    err_count = 0;
    checked = 0;
    void'($urandom(23));
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(OFS_ENABLE, 8'hFF, ENABLE_RST);
    rd_chk(OFS_MODE, 8'hFF, {7'h00, MODE_RST});
    rd_chk(OFS_LATCH, 8'hFF, 8'h20);
    rd_chk(OFS_LATCH, 8'hFF, LATCH_RST);
    rd_chk(8'h40, 8'hFF, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      b = bits[i % 4];
      en = 1'($urandom % 2);
      bus(1'b1, OFS_ENABLE, 8'(en) << b, rd);
      pins[b] <= ~pins[b];
      repeat (6) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 8'h1B, pins & 8'h1B);
      @(negedge sys_clk);
      chk({7'h00, irq}, {7'h00, en});
      @(posedge sys_clk);
      rd_chk(OFS_LATCH, 8'hFF, 8'h01 << b);
      @(negedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      @(posedge sys_clk);
    end
    $display("event test done");
    near_p = 1'b1;
    for (int i = 0; i < 7; i++) begin
      b = $urandom;
      rp <= 5'(b);
      wp <= 5'(b) + dlt[i];
      en = fifo_near(5'(b) + dlt[i], 5'(b));
      repeat (3) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 8'h20, {2'h0, en, 5'h00});
      rd_chk(OFS_LATCH, 8'hFF, {2'h0, en ^ near_p, 5'h00});
      near_p = en;
    end
    $display("fifo test done");
    tx_on <= 1'b0;
    repeat (480) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 8'h40, 8'h00);
    repeat (60) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 8'h40, 8'h40);
    rd_chk(OFS_LATCH, 8'hFF, 8'h40);
    tx_on <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 8'h40, 8'h00);
    rd_chk(OFS_LATCH, 8'hFF, 8'h40);
    $display("drive monitor test done");
    pins[B_LOOP] <= ~pins[B_LOOP];
    repeat (6) @(posedge sys_clk);
    bus(1'b1, OFS_LATCH, 8'h08, rd);
    rd_chk(OFS_LATCH, 8'hFF, 8'h00);
    $display("write clear test done");
    bus(1'b1, OFS_MODE, 8'h00, rd);
    pins[B_LOSS] <= ~pins[B_LOSS];
    repeat (6) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 8'hFF, 8'h00);
    bus(1'b1, OFS_MODE, 8'h01, rd);
    rd_chk(OFS_LATCH, 8'hFF, 8'h00);
    rd_chk(OFS_STATUS, 8'h02, pins & 8'h02);
    $display("mode test done");
    print_verdict();
  end
endmodule : test_liu_channel_status_irq
`default_nettype wire
